// *** rtl/eswp_defs.svh ***
// Constants for the protected-write EEPROM host controller
`ifndef ESWP_DEFS_SVH
`define ESWP_DEFS_SVH
`define ESWP_CLK_MHZ 200
`define ESWP_BYTE_LOAD_MAX_US 100
`define ESWP_BYTE_LOAD_CYC ((`ESWP_BYTE_LOAD_MAX_US * `ESWP_CLK_MHZ) * 9 / 10)
`define ESWP_WRITE_CYCLE_MS 10
`define ESWP_WRITE_CYCLE_CYC (`ESWP_WRITE_CYCLE_MS * 1000 * `ESWP_CLK_MHZ)
`define ESWP_STROBE_CYC 20
`define ESWP_PAGE_MAX 128
`define ESWP_UNLOCK_STEPS 3
`define ESWP_CLEAR_STEPS 6
`define ESWP_PAGE_LSB 7
`endif

// *** rtl/eswp_pkg.sv ***
// Types for the protected-write EEPROM host controller
package eswp_pkg;
  typedef enum logic [1:0] {
    ESWP_CMD_PLAIN,
    ESWP_CMD_UNLOCK,
    ESWP_CMD_CLEAR
  } eswp_cmd_type;
  typedef enum logic [2:0] {
    ESWP_IDLE,
    ESWP_SEQ,
    ESWP_DATA_REQ,
    ESWP_STROBE,
    ESWP_GAP,
    ESWP_SETTLE
  } eswp_state_type;
endpackage

// *** rtl/eswp_host.sv ***
// Host-side controller issuing unlock, data and clear write sequences to the EEPROM
`timescale 1ns/10ps
`include "eswp_defs.svh"

// Function
// - three fixed unlock writes precede data
// - six-write sequence clears protection
// - sequence steps never interrupted
// - chip select follows write strobe, strobes shared
// - page address fixed during load
// - next byte within byte load window
module eswp_host #(
  parameter int ADDR_W = 15,
  parameter int WRITE_CYCLE_CYC = `ESWP_WRITE_CYCLE_CYC,
  parameter logic [14:0] UNLOCK_A0 = 15'h0000,
  parameter logic [14:0] UNLOCK_A1 = 15'h0000,
  parameter logic [14:0] UNLOCK_A2 = 15'h0000,
  parameter logic [7:0] UNLOCK_D0 = 8'h00,
  parameter logic [7:0] UNLOCK_D1 = 8'h00,
  parameter logic [7:0] UNLOCK_D2 = 8'h00,
  parameter logic [14:0] CLEAR_A3 = 15'h0000,
  parameter logic [14:0] CLEAR_A4 = 15'h0000,
  parameter logic [14:0] CLEAR_A5 = 15'h0000,
  parameter logic [7:0] CLEAR_D3 = 8'h00,
  parameter logic [7:0] CLEAR_D4 = 8'h00,
  parameter logic [7:0] CLEAR_D5 = 8'h00
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [1:0] cmd_i,
  input wire logic [ADDR_W-1:0] page_addr_i,
  input wire logic [7:0] len_m1_i,
  output logic busy_o,
  output logic data_req_o,
  input wire logic data_valid_i,
  input wire logic [7:0] data_i,
  output logic done_o,
  output logic len_err_o,
  output logic [ADDR_W-1:0] mem_addr_o,
  output logic [7:0] mem_dq_o,
  output logic mem_dq_oe_o,
  output logic mem_ce_n_o,
  output logic mem_we_n_o,
  output logic mem_oe_n_o
);
  localparam int STEP_CYC = `ESWP_STROBE_CYC;
  localparam int LOAD_CYC = `ESWP_BYTE_LOAD_CYC;
  localparam int CNT_W = 32;

  eswp_pkg::eswp_state_type state_q, state_d;
  eswp_pkg::eswp_cmd_type cmd_q;
  logic [2:0] step_q;
  logic [7:0] byte_q;
  logic [7:0] len_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] load_q;
  logic [ADDR_W-1:0] page_q;
  logic [ADDR_W-1:0] seq_addr;
  logic [7:0] seq_data;
  logic [2:0] seq_len;
  logic seq_last;
  logic page_last;
  logic cnt_done;
  logic load_late;
  logic [2:0] step_nx;
  logic strobe_q;
  logic strobe_d;

  // Fixed command steps; unlock uses three, clear uses six
  assign seq_len = (cmd_q == eswp_pkg::ESWP_CMD_CLEAR) ? 3'(`ESWP_CLEAR_STEPS) :
                   3'(`ESWP_UNLOCK_STEPS);
  // Step about to go out: zero on a fresh command, else the one after the current
  assign step_nx = (state_q == eswp_pkg::ESWP_IDLE) ? 3'h0 : step_q + 3'h1;
  assign seq_addr = (step_nx == 3'h0) ? UNLOCK_A0 : (step_nx == 3'h1) ? UNLOCK_A1 :
                    (step_nx == 3'h2) ? UNLOCK_A2 : (step_nx == 3'h3) ? CLEAR_A3 :
                    (step_nx == 3'h4) ? CLEAR_A4 : CLEAR_A5;
  assign seq_data = (step_nx == 3'h0) ? UNLOCK_D0 : (step_nx == 3'h1) ? UNLOCK_D1 :
                    (step_nx == 3'h2) ? UNLOCK_D2 : (step_nx == 3'h3) ? CLEAR_D3 :
                    (step_nx == 3'h4) ? CLEAR_D4 : CLEAR_D5;
  assign seq_last = (step_q == seq_len - 3'h1);
  assign page_last = (byte_q == len_q);
  assign cnt_done = (cnt_q == '0);
  // Guard against the device starting programming mid-page
  assign load_late = (load_q >= CNT_W'(LOAD_CYC));

  // Next-state logic; sequences run back to back with no foreign access
  always_comb begin
    state_d = state_q;
    case (state_q)
      eswp_pkg::ESWP_IDLE: begin
        if (start_i && cmd_i != 2'h3 && !(len_m1_i > 8'(`ESWP_PAGE_MAX - 1))) begin
          state_d = (cmd_i == 2'(eswp_pkg::ESWP_CMD_PLAIN)) ? eswp_pkg::ESWP_DATA_REQ :
                    eswp_pkg::ESWP_SEQ;
        end
      end
      eswp_pkg::ESWP_SEQ: begin
        if (cnt_done) begin
          state_d = eswp_pkg::ESWP_GAP;
        end
      end
      eswp_pkg::ESWP_DATA_REQ: begin
        if (load_late) begin
          state_d = eswp_pkg::ESWP_SETTLE;
        end else if (data_valid_i) begin
          state_d = eswp_pkg::ESWP_STROBE;
        end
      end
      eswp_pkg::ESWP_STROBE: begin
        if (cnt_done) begin
          state_d = eswp_pkg::ESWP_GAP;
        end
      end
      eswp_pkg::ESWP_GAP: begin
        if (cnt_done) begin
          if (step_q != 3'h7 && !seq_last) begin
            state_d = eswp_pkg::ESWP_SEQ;
          end else if (cmd_q == eswp_pkg::ESWP_CMD_CLEAR ||
                       (step_q == 3'h7 && page_last)) begin
            state_d = eswp_pkg::ESWP_SETTLE;
          end else begin
            state_d = eswp_pkg::ESWP_DATA_REQ;
          end
        end
      end
      eswp_pkg::ESWP_SETTLE: begin
        if (cnt_done) begin
          state_d = eswp_pkg::ESWP_IDLE;
        end
      end
      default: state_d = eswp_pkg::ESWP_IDLE;
    endcase
  end

  // Sequencing registers; step 7 marks the data phase
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_q <= eswp_pkg::ESWP_IDLE;
      cmd_q <= eswp_pkg::ESWP_CMD_PLAIN;
      step_q <= 3'h0;
      byte_q <= 8'h00;
      len_q <= 8'h00;
      page_q <= '0;
      cnt_q <= '0;
      load_q <= '0;
    end else begin
      state_q <= state_d;
      if (state_q == eswp_pkg::ESWP_IDLE && state_d != eswp_pkg::ESWP_IDLE) begin
        cmd_q <= eswp_pkg::eswp_cmd_type'(cmd_i);
        step_q <= (cmd_i == 2'(eswp_pkg::ESWP_CMD_PLAIN)) ? 3'h7 : 3'h0;
        byte_q <= 8'h00;
        len_q <= len_m1_i;
        page_q <= page_addr_i;
        cnt_q <= CNT_W'(STEP_CYC);
        load_q <= '0;
      end else begin
        if (state_q != eswp_pkg::ESWP_IDLE) begin
          load_q <= load_q + CNT_W'(1);
        end
        if (!cnt_done) begin
          cnt_q <= cnt_q - CNT_W'(1);
        end
        if (state_q == eswp_pkg::ESWP_GAP && cnt_done) begin
          cnt_q <= (state_d == eswp_pkg::ESWP_SETTLE) ? CNT_W'(WRITE_CYCLE_CYC) :
                   CNT_W'(STEP_CYC);
          if (step_q != 3'h7) begin
            step_q <= seq_last ? 3'h7 : step_q + 3'h1;
          end else begin
            byte_q <= byte_q + 8'h01;
          end
        end
        if (state_q == eswp_pkg::ESWP_DATA_REQ && data_valid_i && !load_late) begin
          cnt_q <= CNT_W'(STEP_CYC);
          load_q <= '0; // Window restarts as each data byte is taken, a cycle before its strobe falls
        end
        if (state_q == eswp_pkg::ESWP_DATA_REQ && load_late) begin
          cnt_q <= CNT_W'(WRITE_CYCLE_CYC);
        end
        if ((state_q == eswp_pkg::ESWP_SEQ || state_q == eswp_pkg::ESWP_STROBE) &&
            cnt_done) begin
          cnt_q <= CNT_W'(STEP_CYC);
        end
      end
    end
  end

  // Strobes follow the registered state, so address leads the falling edge by a cycle
  assign strobe_q = (state_q == eswp_pkg::ESWP_SEQ || state_q == eswp_pkg::ESWP_STROBE);
  assign strobe_d = (state_d == eswp_pkg::ESWP_SEQ || state_d == eswp_pkg::ESWP_STROBE);

  // Pin drivers; chip select only during a write, so the part stays idle otherwise
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      mem_ce_n_o <= 1'b1;
      mem_we_n_o <= 1'b1;
      mem_oe_n_o <= 1'b1;
      mem_dq_oe_o <= 1'b0;
      mem_addr_o <= '0;
      mem_dq_o <= 8'h00;
    end else begin
      mem_oe_n_o <= 1'b1;
      mem_ce_n_o <= !strobe_q;
      mem_we_n_o <= !strobe_q;
      // Data held one cycle past the rising strobe, where the part latches it
      mem_dq_oe_o <= strobe_d || strobe_q || !mem_we_n_o;
      if (state_d == eswp_pkg::ESWP_SEQ && state_q != eswp_pkg::ESWP_SEQ) begin
        mem_addr_o <= seq_addr;
        mem_dq_o <= seq_data;
      end
      if (state_d == eswp_pkg::ESWP_STROBE && state_q == eswp_pkg::ESWP_DATA_REQ) begin
        mem_addr_o <= {page_q[ADDR_W-1:`ESWP_PAGE_LSB], byte_q[`ESWP_PAGE_LSB-1:0]};
        mem_dq_o <= data_i;
      end
    end
  end

  // Status outputs; relock and persistence live in the device
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
      data_req_o <= 1'b0;
      done_o <= 1'b0;
      len_err_o <= 1'b0;
    end else begin
      busy_o <= (state_d != eswp_pkg::ESWP_IDLE);
      data_req_o <= (state_d == eswp_pkg::ESWP_DATA_REQ);
      done_o <= (state_q == eswp_pkg::ESWP_SETTLE && cnt_done);
      len_err_o <= (state_q == eswp_pkg::ESWP_IDLE && start_i &&
                    (cmd_i == 2'h3 || len_m1_i > 8'(`ESWP_PAGE_MAX - 1)));
    end
  end
endmodule // eswp_host

// *** dv/eswp_host_chk.sv ***
// Concurrent checks on the host controller ports
`timescale 1ns/10ps
module eswp_host_chk #(
  parameter int ADDR_W = 15
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [1:0] cmd_i,
  input wire logic [7:0] len_m1_i,
  input wire logic busy_o,
  input wire logic data_req_o,
  input wire logic data_valid_i,
  input wire logic len_err_o,
  input wire logic [ADDR_W-1:0] mem_addr_o,
  input wire logic [7:0] mem_dq_o,
  input wire logic mem_dq_oe_o,
  input wire logic mem_ce_n_o,
  input wire logic mem_we_n_o,
  input wire logic mem_oe_n_o
);
  logic [7:0] lo_q;
  logic [15:0] gap_q;
  logic we_q;
  // Strobe low time and fall-to-fall spacing; spacing restarts while idle
  always_ff @(posedge core_clk_i) begin
    we_q <= rst_i | mem_we_n_o;
    lo_q <= (rst_i | mem_we_n_o) ? 8'h00 : lo_q + 8'h01;
    gap_q <= (rst_i | !busy_o | (we_q & !mem_we_n_o)) ? 16'h0000 : gap_q + 16'h0001;
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_fall;
    $fell(mem_we_n_o);
  endsequence
  rst_idle_a: assert property (disable iff (1'b0) rst_i |=> mem_ce_n_o && mem_we_n_o
    && !mem_dq_oe_o) else $error("bus not idle after reset");
  no_read_a: assert property (mem_oe_n_o) else $error("read inserted");
  sel_we_a: assert property (mem_ce_n_o |-> mem_we_n_o) else $error("strobe unselected");
  wr_drive_a: assert property (!mem_we_n_o |-> mem_dq_oe_o) else $error("data undriven");
  // A step state lasts its load count plus one cycle, so the strobe is low 21 cycles
  strobe_len_a: assert property ($rose(mem_we_n_o) |-> lo_q == 8'h15)
    else $error("strobe not 21 cycles");
  data_hold_a: assert property ($rose(mem_we_n_o) |-> mem_dq_oe_o)
    else $error("data released at strobe rise");
  addr_hold_a: assert property (!mem_we_n_o && !$past(mem_we_n_o) |->
    $stable(mem_addr_o) && $stable(mem_dq_o)) else $error("bus moved in strobe");
  load_gap_a: assert property (s_fall |-> gap_q < 16'h4E20) else $error("byte gap too long");
  first_step_a: assert property (start_i && !busy_o && cmd_i == 2'h1 && !len_m1_i[7]
    |=> !data_req_o [*8]) else $error("data before unlock");
  len_err_a: assert property (start_i && !busy_o && (cmd_i == 2'h3 || len_m1_i[7])
    |=> len_err_o && !busy_o) else $error("bad start not refused");
  take_a: assert property (data_req_o && data_valid_i |-> ##[1:3] s_fall)
    else $error("byte not written");
endmodule // eswp_host_chk
bind eswp_host eswp_host_chk #(.ADDR_W(ADDR_W)) i_eswp_host_chk (.core_clk_i, .rst_i, .start_i,
  .cmd_i, .len_m1_i, .busy_o, .data_req_o, .data_valid_i, .len_err_o, .mem_addr_o, .mem_dq_o,
  .mem_dq_oe_o, .mem_ce_n_o, .mem_we_n_o, .mem_oe_n_o);

// *** dv/eswp_mem.sv ***
// Behavioural protected-write EEPROM answering the host controller
`timescale 1ns/10ps
module eswp_mem #(
  parameter logic [5:0][14:0] SA = '0,
  parameter logic [5:0][7:0] SD = '0
) (
  input wire logic [14:0] addr_i,
  input wire logic [7:0] dq_i,
  input wire logic ce_n_i,
  input wire logic we_n_i,
  input wire logic oe_n_i
);
  logic [7:0] mem [32768];
  logic prot = 1'b0;
  logic win = 1'b0;
  int seq = 0;
  int nacc = 0;
  logic [14:0] a_q;
  time t_q = 0;
  time g_q = 0;
  wire wr_n = ce_n_i | we_n_i | !oe_n_i;
  // Address on the later falling edge; spacing to the previous load kept
  always @(negedge wr_n) begin
    a_q = addr_i;
    g_q = $time - t_q;
    t_q = $time;
  end
  // Data on the earlier rising edge; protection has no reset, as in flash cells
  always @(posedge wr_n) begin
    if (g_q > 100000) win = 1'b0;
    if (seq < 6 && a_q == SA[seq] && dq_i == SD[seq]) begin
      seq++;
      if (seq == 3) win = 1'b1;
      if (seq == 6) begin
        prot = 1'b0;
        win = 1'b0;
        seq = 0;
      end
    end else begin
      if (!prot || win) begin
        mem[a_q] = dq_i;
        nacc++;
        prot = prot | win;
      end
      seq = 0;
    end
  end
endmodule // eswp_mem

// *** dv/eswp_host_tb.sv ***
// Testbench for the protected-write EEPROM host controller
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
  $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
module eswp_host_tb;
  localparam logic [5:0][14:0] SA = {15'h0ACE, 15'h0BAD, 15'h0CAB, 15'h1ABC, 15'h0567, 15'h1234};
  localparam logic [5:0][7:0] SD = {8'hD6, 8'hE5, 8'hF4, 8'hC3, 8'hB2, 8'hA1};
  logic core_clk_i = 1'b0, rst_i = 1'b1, start_i = 1'b0, data_valid_i = 1'b0;
  logic [1:0] cmd_i = 2'h0;
  logic [14:0] page_addr_i = 15'h0000, mem_addr_o;
  logic [7:0] len_m1_i = 8'h00, data_i = 8'h00, mem_dq_o;
  logic busy_o, data_req_o, done_o, len_err_o, mem_dq_oe_o, mem_ce_n_o, mem_we_n_o, mem_oe_n_o;
  int errors = 0, checked = 0, n, base;
  // Released data lines show the inverse so stale values never match
  wire [7:0] dq_bus = mem_dq_oe_o ? mem_dq_o : ~mem_dq_o;
  always #2.5 core_clk_i = ~core_clk_i;
  eswp_host #(.WRITE_CYCLE_CYC(50), .UNLOCK_A0(SA[0]), .UNLOCK_A1(SA[1]), .UNLOCK_A2(SA[2]),
    .CLEAR_A3(SA[3]), .CLEAR_A4(SA[4]), .CLEAR_A5(SA[5]), .UNLOCK_D0(SD[0]), .UNLOCK_D1(SD[1]),
    .UNLOCK_D2(SD[2]), .CLEAR_D3(SD[3]), .CLEAR_D4(SD[4]), .CLEAR_D5(SD[5])) i_eswp_host (
    .core_clk_i, .rst_i, .start_i, .cmd_i, .page_addr_i, .len_m1_i, .busy_o, .data_req_o,
    .data_valid_i, .data_i, .done_o, .len_err_o, .mem_addr_o, .mem_dq_o, .mem_dq_oe_o,
    .mem_ce_n_o, .mem_we_n_o, .mem_oe_n_o);
  eswp_mem #(.SA(SA), .SD(SD)) i_eswp_mem (.addr_i(mem_addr_o), .dq_i(dq_bus),
    .ce_n_i(mem_ce_n_o), .we_n_i(mem_we_n_o), .oe_n_i(mem_oe_n_o));
  task automatic end_of_test();
    if (errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // One command; bytes offered whenever requested, wait bounded
  task automatic run(input logic [1:0] c, input logic [14:0] p, input logic [7:0] l);
    int k;
    n = 0;
    base = i_eswp_mem.nacc;
    cmd_i = c;
    page_addr_i = p;
    len_m1_i = l;
    start_i = 1'b1;
    @(posedge core_clk_i);
    #1 start_i = 1'b0;
    for (k = 0; k < 9000 && done_o !== 1'b1; k++) begin
      @(posedge core_clk_i);
      #1;
      if (data_valid_i) n++;
      data_valid_i = data_req_o;
      data_i = 8'h30 + n[7:0];
    end
    if (k == 9000) begin
      errors++;
      end_of_test();
    end
    @(posedge core_clk_i);
    #1;
  endtask
  task automatic s_plain();
    run(2'h0, 15'h4000, 8'h01);
    `CHK(i_eswp_mem.nacc - base, 2)
    `CHK(i_eswp_mem.mem[15'h4001], 8'h31)
  endtask
  task automatic s_unlock();
    run(2'h1, 15'h4080, 8'h7F);
    `CHK(n, 128)
    `CHK(i_eswp_mem.nacc - base, 128)
    `CHK(i_eswp_mem.mem[15'h40FF], 8'hAF)
    `CHK(i_eswp_mem.prot, 1'b1)
  endtask
  // Past the 100 us load window the device has relocked
  task automatic s_block();
    repeat (21000) @(posedge core_clk_i);
    #1 run(2'h0, 15'h4100, 8'h00);
    `CHK(i_eswp_mem.nacc - base, 0)
    `CHK(i_eswp_mem.prot, 1'b1)
  endtask
  task automatic s_clear();
    run(2'h2, 15'h0000, 8'h00);
    `CHK(i_eswp_mem.prot, 1'b0)
    run(2'h0, 15'h4180, 8'h00);
    `CHK(i_eswp_mem.nacc - base, 1)
    run(2'h1, 15'h4200, 8'h00);
    `CHK(i_eswp_mem.nacc - base, 1)
    `CHK(i_eswp_mem.mem[15'h4200], 8'h30)
  endtask
  task automatic s_refuse();
    for (int i = 0; i < 2; i++) begin
      cmd_i = i ? 2'h0 : 2'h3;
      len_m1_i = i ? 8'h80 : 8'h00;
      start_i = 1'b1;
      @(posedge core_clk_i);
      #1;
      `CHK(len_err_o, 1'b1)
      `CHK(busy_o, 1'b0)
    end
    start_i = 1'b0;
  endtask
  initial begin
    repeat (12) @(posedge core_clk_i);
    #1 rst_i = 1'b0;
    s_plain();
    s_unlock();
    s_block();
    s_clear();
    s_refuse();
    end_of_test();
  end
endmodule // eswp_host_tb
